//--- hw/ssup_pkg.sv
// Package with the constants and carrier types of the supply reset supervisor.
package ssup_pkg;

	// Timebase rate in kHz, so millisecond times convert without large products.
	localparam int SSUP_CLK_KHZ = 125000;
	// Reset stretch time in milliseconds.
	localparam int SSUP_STRETCH_MS = 200;
	// Watchdog timeout in milliseconds.
	localparam int SSUP_WDOG_MS = 1600;
	// Derived cycle counts; both exceed 4096 and are overridable at the top.
	localparam int SSUP_STRETCH_CYC = SSUP_STRETCH_MS * SSUP_CLK_KHZ;
	localparam int SSUP_WDOG_CYC = SSUP_WDOG_MS * SSUP_CLK_KHZ;
	// Width of the cycle counters.
	localparam int SSUP_CNT_W = 32;
	// Number of asynchronous level inputs that pass the synchroniser.
	localparam int SSUP_SYNC_W = 5;
	// Reset value of the synchroniser stages, in struct order: supply good, manual reset released,
	// kick low, kick driven, sense above reference, so no source appears active just after reset.
	localparam logic [SSUP_SYNC_W-1:0] SSUP_SYNC_RST = 5'h09;

	// Synchronised view of the pins.
	typedef struct packed {
		logic supply_low;
		logic manual_reset_n;
		logic kick;
		logic kick_float;
		logic power_fail_n;
	} ssup_pins_type;

endpackage : ssup_pkg

//--- hw/ssup_sync.sv
// Two flip-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module ssup_sync
	import ssup_pkg::*;
#(
	parameter int WIDTH = SSUP_SYNC_W,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : ssup_sync

//--- hw/ssup_top.sv
// Supply reset supervisor: reset stretch, manual reset, watchdog and power-fail flag.
// Operation
// - Reset output is low while the supply-low indication is active.
// - Reset stays low 200 ms after supply recovers or manual reset rises.
// - A low manual reset input asserts the reset output.
// - Manual reset input is debounced inside the device.
// - Alarm goes low when kick input does not change within 1.6 s.
// - Any kick edge clears the watchdog counter; processor must toggle in time.
// - Watchdog counter is held cleared while reset is asserted.
// - A floating kick input disables watchdog timeout detection.
// - After a timeout the alarm stays low until the counter is cleared.
// - Alarm is forced low while the supply-low indication is active.
// - Alarm releases high at once when the supply recovers.
// - A watchdog timeout never asserts the reset output by itself.
// - Active-high reset output is always the inverse of the low one.
// - Power-fail flag is low while sense input is below reference.
// - Variants with active-high reset have no watchdog function; here RESET_OUT exists with the watchdog too.
// - Manual reset is debounced by the reset stretch period itself.
`timescale 1ns/1ps
module ssup_top
	import ssup_pkg::*;
#(
	parameter int STRETCH_CYC = SSUP_STRETCH_CYC,
	parameter int WDOG_CYC = SSUP_WDOG_CYC,
	parameter bit HAS_WATCHDOG = 1'h1
) (
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire logic SUPPLY_LOW_IN,
	input wire logic MANUAL_RESET_IN_N,
	input wire logic WATCHDOG_KICK_IN,
	input wire logic WATCHDOG_KICK_FLOAT_IN,
	input wire logic POWER_FAIL_SENSE_IN,
	output logic RESET_OUT_N,
	output logic RESET_OUT,
	output logic WATCHDOG_ALARM_OUT_N,
	output logic POWER_FAIL_FLAG_OUT_N
);

	// Elaboration check: counters must fit and a stretch shorter than two cycles could not be measured.
	if (STRETCH_CYC < 2 || WDOG_CYC < 2 || STRETCH_CYC > 32'h7fffffff || WDOG_CYC > 32'h7fffffff) begin : g_chk
		$error("ssup_top: cycle counts out of range");
	end

	localparam logic [SSUP_CNT_W-1:0] STRETCH_LAST = SSUP_CNT_W'(STRETCH_CYC - 1);
	localparam logic [SSUP_CNT_W-1:0] WDOG_LAST = SSUP_CNT_W'(WDOG_CYC - 1);

	ssup_pins_type pins;
	logic [SSUP_SYNC_W-1:0] sync_bus;
	logic kick_prev_r;
	logic kick_edge;
	logic hold;
	logic [SSUP_CNT_W-1:0] stretch_cnt_r;
	logic [SSUP_CNT_W-1:0] stretch_cnt_nxt;
	logic [SSUP_CNT_W-1:0] wdog_cnt_r;
	logic timed_out_r;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation.

	// Every level input is asynchronous to the timebase, so all five pass two flip-flops.
	ssup_sync #(
		.WIDTH(SSUP_SYNC_W),
		.RST_VAL(SSUP_SYNC_RST)
	) ssup_sync_inst (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.async_in({SUPPLY_LOW_IN, MANUAL_RESET_IN_N, WATCHDOG_KICK_IN, WATCHDOG_KICK_FLOAT_IN, POWER_FAIL_SENSE_IN}),
		.sync_out(sync_bus)
	);
	assign pins = sync_bus;

	////////////////////////////////////////////////////////////////////////////////
	// Reset generation.

	// Either source holds the stretch counter at zero; the watchdog is not a source.
	assign hold = pins.supply_low | ~pins.manual_reset_n;

	// Counter restarts on every low sample of the manual input, so bounces only lengthen the pulse.
	always_comb begin
		if (hold) begin
			stretch_cnt_nxt = '0;
		end else if (stretch_cnt_r != STRETCH_LAST) begin
			stretch_cnt_nxt = stretch_cnt_r + 1'h1;
		end else begin
			stretch_cnt_nxt = stretch_cnt_r;
		end
	end

	// Reset is low from power-up until the stretch has run out.
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			stretch_cnt_r <= '0;
			RESET_OUT_N <= 1'h0;
			RESET_OUT <= 1'h1;
		end else begin
			stretch_cnt_r <= stretch_cnt_nxt;
			RESET_OUT_N <= ~hold & (stretch_cnt_nxt == STRETCH_LAST);
			RESET_OUT <= hold | (stretch_cnt_nxt != STRETCH_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog.

	// Edge detector on the second synchroniser stage.
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			kick_prev_r <= 1'h0;
		end else begin
			kick_prev_r <= pins.kick;
		end
	end
	assign kick_edge = pins.kick ^ kick_prev_r;

	// Counter clears on any edge, while reset is low, or when the input floats.
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wdog_cnt_r <= '0;
			timed_out_r <= 1'h0;
		end else if (!HAS_WATCHDOG || kick_edge || !RESET_OUT_N || pins.kick_float) begin
			wdog_cnt_r <= '0;
			timed_out_r <= 1'h0;
		end else if (wdog_cnt_r == WDOG_LAST) begin
			timed_out_r <= 1'h1;
		end else begin
			wdog_cnt_r <= wdog_cnt_r + 1'h1;
		end
	end

	// Low on timeout or low supply; release follows supply recovery directly.
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WATCHDOG_ALARM_OUT_N <= 1'h1;
		end else begin
			WATCHDOG_ALARM_OUT_N <= !HAS_WATCHDOG | ~(timed_out_r | pins.supply_low);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-fail flag.

	// The sense input is the comparator result: high means above reference.
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			POWER_FAIL_FLAG_OUT_N <= 1'h1;
		end else begin
			POWER_FAIL_FLAG_OUT_N <= pins.power_fail_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	property p_supply_reset;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) pins.supply_low |=> !RESET_OUT_N;
	endproperty
	a_supply_reset: assert property (p_supply_reset) else $error("reset high during low supply");

	property p_manual_reset;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) !pins.manual_reset_n |=> !RESET_OUT_N;
	endproperty
	a_manual_reset: assert property (p_manual_reset) else $error("reset high during manual reset");

	property p_stretch;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) $rose(RESET_OUT_N) |-> $past(stretch_cnt_r) == STRETCH_LAST - 1'h1;
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset released before the stretch ended");

	property p_inverse;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) RESET_OUT == !RESET_OUT_N;
	endproperty
	a_inverse: assert property (p_inverse) else $error("reset outputs not complementary");

	property p_hold_cleared;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) !RESET_OUT_N |=> wdog_cnt_r == '0;
	endproperty
	a_hold_cleared: assert property (p_hold_cleared) else $error("watchdog counted during reset");

	property p_timeout;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) timed_out_r |=> !WATCHDOG_ALARM_OUT_N;
	endproperty
	a_timeout: assert property (p_timeout) else $error("alarm high after timeout");

	property p_float;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) pins.kick_float |=> !timed_out_r;
	endproperty
	a_float: assert property (p_float) else $error("timeout while kick floats");

	property p_alarm_release;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) !pins.supply_low && !timed_out_r |=> WATCHDOG_ALARM_OUT_N;
	endproperty
	a_alarm_release: assert property (p_alarm_release) else $error("alarm low without cause");

	property p_no_wdog_reset;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) !hold && RESET_OUT_N |=> RESET_OUT_N;
	endproperty
	a_no_wdog_reset: assert property (p_no_wdog_reset) else $error("reset without a reset source");

	property p_power_fail;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) 1'h1 |=> POWER_FAIL_FLAG_OUT_N == $past(pins.power_fail_n);
	endproperty
	a_power_fail: assert property (p_power_fail) else $error("power-fail flag does not follow sense");

	property p_kick_clear;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) kick_edge |=> wdog_cnt_r == '0;
	endproperty
	a_kick_clear: assert property (p_kick_clear) else $error("watchdog counter kept after a kick edge");

	property p_reach_timeout;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
			HAS_WATCHDOG && RESET_OUT_N && !kick_edge && !pins.kick_float && wdog_cnt_r == WDOG_LAST |=> timed_out_r;
	endproperty
	a_reach_timeout: assert property (p_reach_timeout) else $error("no timeout after a full period");

	property p_supply_alarm;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) HAS_WATCHDOG && pins.supply_low |=> !WATCHDOG_ALARM_OUT_N;
	endproperty
	a_supply_alarm: assert property (p_supply_alarm) else $error("alarm high during low supply");

	property p_no_watchdog;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN) !HAS_WATCHDOG |-> WATCHDOG_ALARM_OUT_N && wdog_cnt_r == '0;
	endproperty
	a_no_watchdog: assert property (p_no_watchdog) else $error("watchdog active in the variant without it");

	c_release: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) $rose(RESET_OUT_N));
	c_timeout: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) $rose(timed_out_r));
	c_kick: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) kick_edge && RESET_OUT_N);
	c_pfail: cover property (@(posedge CLOCK_IN) disable iff (!RST_N_IN) $fell(POWER_FAIL_FLAG_OUT_N));

endmodule : ssup_top

//--- verification/ssup_cpu_model.sv
// Processor model that drives the watchdog kick line of the supervisor.
`timescale 1ns/1ps
module ssup_cpu_model #(
	parameter int PERIOD = 20
) (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic kick_req_in,
	output logic kick_out
);
	int cnt;
	// Start from a known low level so the first toggle is a clean rising edge.
	initial begin
		kick_out = 1'b0;
		cnt = 0;
	end
	// A healthy program toggles well inside the timeout; a single request gives one edge.
	always @(posedge clk_in) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		if (kick_req_in || (run_in && cnt == 0)) begin
			kick_out <= #1 ~kick_out;
		end
	end
endmodule : ssup_cpu_model

//--- verification/ssup_top_tb_top.sv
// Self-checking testbench of the supply reset supervisor.
`timescale 1ns/1ps
module ssup_top_tb_top;
	localparam int STR = 50;
	localparam int WD = 100;
	logic clk, rst_n, supply_low, mr_n, kick, kick_float, sense, run, kick_req;
	logic rst_out_n, rst_out, alarm_n, pf_n;
	logic v_rst_out_n, v_rst_out, v_alarm_n, v_pf_n;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////
	// Short counts keep the run brief; every expectation derives from them.
	ssup_top #(.STRETCH_CYC(STR), .WDOG_CYC(WD), .HAS_WATCHDOG(1'b1)) ssup_top_inst (
		.CLOCK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_LOW_IN(supply_low),
		.MANUAL_RESET_IN_N(mr_n), .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_FLOAT_IN(kick_float),
		.POWER_FAIL_SENSE_IN(sense), .RESET_OUT_N(rst_out_n), .RESET_OUT(rst_out),
		.WATCHDOG_ALARM_OUT_N(alarm_n), .POWER_FAIL_FLAG_OUT_N(pf_n));
	ssup_cpu_model #(.PERIOD(20)) ssup_cpu_model_inst (
		.clk_in(clk), .run_in(run), .kick_req_in(kick_req), .kick_out(kick));
	// Variant without a watchdog sees the same pins; its alarm must never fall.
	if (1) begin : g_variant
		ssup_top #(.STRETCH_CYC(STR), .WDOG_CYC(WD), .HAS_WATCHDOG(1'b0)) ssup_top_inst (
			.CLOCK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_LOW_IN(supply_low),
			.MANUAL_RESET_IN_N(mr_n), .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_FLOAT_IN(kick_float),
			.POWER_FAIL_SENSE_IN(sense), .RESET_OUT_N(v_rst_out_n), .RESET_OUT(v_rst_out),
			.WATCHDOG_ALARM_OUT_N(v_alarm_n), .POWER_FAIL_FLAG_OUT_N(v_pf_n));
	end
	////////////////////////////////////////////////////////////////////////////
	// Clock of 8 ns and a cycle ceiling that cuts a hang short.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			final_report();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic check_bit(input string name, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %b seen %b", name, exp, seen);
		end
	endtask : check_bit
	task automatic final_report();
		if (fails == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////
	// Scenarios, each judging its own outcome.
	task automatic t_power_on();
		check_bit("reset_n in reset", rst_out_n, 1'b0);
		check_bit("reset in reset", rst_out, 1'b1);
		rst_n = 1'b1;
		tick(STR - 5);
		check_bit("reset_n stretching", rst_out_n, 1'b0);
		tick(12);
		check_bit("reset_n released", rst_out_n, 1'b1);
		check_bit("reset released", rst_out, 1'b0);
		check_bit("variant reset_n released", v_rst_out_n, 1'b1);
		check_bit("alarm idle", alarm_n, 1'b1);
	endtask : t_power_on
	task automatic t_supply();
		supply_low = 1'b1;
		tick(4);
		check_bit("reset_n supply low", rst_out_n, 1'b0);
		check_bit("reset supply low", rst_out, 1'b1);
		check_bit("alarm supply low", alarm_n, 1'b0);
		check_bit("variant alarm supply low", v_alarm_n, 1'b1);
		check_bit("variant reset supply low", v_rst_out, 1'b1);
		tick(20);
		supply_low = 1'b0;
		tick(4);
		check_bit("alarm recovered", alarm_n, 1'b1);
		check_bit("reset_n after recovery", rst_out_n, 1'b0);
		tick(STR - 10);
		check_bit("reset_n stretch end", rst_out_n, 1'b0);
		tick(14);
		check_bit("reset_n supply done", rst_out_n, 1'b1);
	endtask : t_supply
	task automatic t_manual();
		mr_n = 1'b0;
		tick(4);
		check_bit("reset_n manual", rst_out_n, 1'b0);
		mr_n = 1'b1;
		tick(20);
		mr_n = 1'b0;
		tick(1);
		mr_n = 1'b1;
		tick(STR - 6);
		check_bit("reset_n after bounce", rst_out_n, 1'b0);
		tick(12);
		check_bit("reset_n manual done", rst_out_n, 1'b1);
	endtask : t_manual
	task automatic t_watchdog(input logic flt);
		kick_float = flt;
		run = 1'b0;
		kick_req = 1'b1;
		tick(1);
		kick_req = 1'b0;
		tick(WD - 10);
		check_bit("alarm before timeout", alarm_n, 1'b1);
		tick(20);
		check_bit("alarm after timeout", alarm_n, flt);
		check_bit("reset_n on timeout", rst_out_n, 1'b1);
		check_bit("variant alarm on timeout", v_alarm_n, 1'b1);
		tick(30);
		check_bit("alarm held", alarm_n, flt);
		kick_req = 1'b1;
		tick(1);
		kick_req = 1'b0;
		kick_float = 1'b0;
		run = 1'b1;
		tick(5);
		check_bit("alarm after kick", alarm_n, 1'b1);
	endtask : t_watchdog
	task automatic t_power_fail();
		sense = 1'b0;
		tick(4);
		check_bit("pf flag low", pf_n, 1'b0);
		check_bit("variant pf flag low", v_pf_n, 1'b0);
		sense = 1'b1;
		tick(4);
		check_bit("pf flag high", pf_n, 1'b1);
	endtask : t_power_fail
	////////////////////////////////////////////////////////////////////////////
	// Main sequence with reset held for eight cycles.
	initial begin
		rst_n = 1'b0;
		supply_low = 1'b0;
		mr_n = 1'b1;
		kick_float = 1'b0;
		sense = 1'b1;
		run = 1'b1;
		kick_req = 1'b0;
		tick(8);
		t_power_on();
		t_supply();
		t_manual();
		t_watchdog(1'b0);
		t_watchdog(1'b1);
		t_power_fail();
		final_report();
	end
endmodule : ssup_top_tb_top
